/* bench/mac_model.sv */
// transmit-side MAC stand-in pushing one packet of words into the serial path
`timescale 1ns/10ps
module mac_model (
  // clock and control
  input  wire logic       mclk,
  input  wire logic       go,
  // transmit words toward the block
  input  wire logic       mac_tx_ready,
  output logic      [9:0] mac_tx_word,
  output logic            mac_tx_err,
  output logic            mac_tx_sop,
  output logic            mac_tx_valid,
  // words accepted so far
  output int              sent
);
  initial begin
    mac_tx_word  = 10'h003;
    mac_tx_err   = 1'b0;
    mac_tx_sop   = 1'b1;
    mac_tx_valid = 1'b0;
    sent         = 0;
  end
  // valid and word are held until the edge that sees ready high
  always @(posedge mclk) begin
    if (mac_tx_valid && mac_tx_ready) begin
      sent         <= sent + 1;
      mac_tx_sop   <= 1'b0;
      // one word carries a transmit error so the substitution is exercised
      mac_tx_err   <= (sent == 5);
      mac_tx_word  <= 10'(sent * 7 + 10);
      mac_tx_valid <= (sent < 39);
    end else if (go && sent < 40) begin
      mac_tx_valid <= 1'b1;
    end
  end
endmodule : mac_model

/* bench/mac_serial_if_config_test.sv */
// self-checking bench for the serial interface configuration block
`timescale 1ns/10ps
module mac_serial_if_config_test;
  logic        mclk, rst, awvalid, wvalid, bready, arvalid, rready, go;
  logic        lpi_active, lpi_exit, core_rx_ctrl, strap_bit_zero, strap_bit_one, strap_bit_two;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, d;
  logic [1:0]  r, b;
  logic [3:0]  core_rxd;
  logic [9:0]  serdes_rx_word;
  wire         awready, wready, bvalid, arready, rvalid, par_rx_ctrl, mac_tx_err, mac_tx_sop;
  wire         mac_tx_valid, mac_tx_ready, serial_en, non_eee_mode, an_complete, rx_sync;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [3:0]  par_rxd;
  wire  [9:0]  mac_rx_word, mac_tx_word, serdes_tx_word;
  wire  [4:0]  tx_refresh_timer, tx_quiet_timer, tx_sleep_timer;
  int          fail_count, tests_run, cyc, sent;
  logic [15:0] mdl [int];
  logic        rx_hold;
  logic [9:0]  rx_fix, pw, last_tx;
  logic [9:0]  txq [$];

  ser_cfg #(.AN_CYC_1P6MS(20), .AN_CYC_800US(10), .AN_CYC_11MS(40)) u_ser_cfg (
    .mclk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .strap_bit_zero, .strap_bit_one, .strap_bit_two, .lpi_active, .lpi_exit, .core_rxd,
    .core_rx_ctrl, .par_rxd, .par_rx_ctrl, .serdes_rx_word, .mac_rx_word, .mac_tx_word,
    .mac_tx_err, .mac_tx_sop, .mac_tx_valid, .mac_tx_ready, .serdes_tx_word, .serial_en,
    .non_eee_mode, .tx_refresh_timer, .tx_quiet_timer, .tx_sleep_timer, .an_complete, .rx_sync
  );
  mac_model u_mac_model (
    .mclk, .go, .mac_tx_ready, .mac_tx_word, .mac_tx_err, .mac_tx_sop, .mac_tx_valid, .sent
  );

  always #2.5 mclk = ~mclk;
  // receive-side stimulus keeps changing so the wake path cannot pass it through unseen
  always @(posedge mclk) begin
    serdes_rx_word <= rx_hold ? rx_fix : 10'($urandom);
    core_rxd       <= 4'($urandom);
    core_rx_ctrl   <= 1'($urandom);
    cyc            <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      results();
    end
  end

  // serial transmit model: accepted words in order, error words replaced, lsb first
  always @(posedge mclk) begin
    last_tx <= serdes_tx_word;
    if (mac_tx_valid && mac_tx_ready) txq.push_back(mac_tx_err ? 10'h2e8 : mac_tx_word);
    if (!rst && serdes_tx_word !== last_tx && serdes_tx_word != 10'h0 &&
        serdes_tx_word != rv(10'h283))
      chk("serdes_tx_word", {22'h0, txq.size() ? rv(txq.pop_front()) : 10'h0},
          {22'h0, serdes_tx_word});
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  function automatic logic [9:0] rv(input logic [9:0] w);
    for (int i = 0; i < 10; i++) rv[i] = w[9-i];
  endfunction : rv

  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    logic done;
    done = 1'b0;
    @(posedge mclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {16'h0, v};
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!done) begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      done = bvalid;
    end
    b = bresp;
    bready <= 1'b0;
    mdl[a] = v;
  endtask : wr

  task automatic rd(input logic [15:0] a);
    @(posedge mclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  // read a mapped register and compare against the bench model
  task automatic rc(input logic [15:0] a);
    rd(a);
    chk("rdata", {16'h0, mdl[a]}, d);
    chk("rresp", 32'h0, {30'h0, r});
  endtask : rc

  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  initial begin
    {mclk, awvalid, wvalid, bready, arvalid, rready, go, lpi_active, lpi_exit, rx_hold} = '0;
    {strap_bit_zero, strap_bit_one, strap_bit_two} = '0;
    {awaddr, araddr, wdata} = '0;
    {fail_count, tests_run, cyc} = '0;
    rst = 1'b1;
    void'($urandom(7067));
    mdl[16'h180c] = 16'h0003;
    mdl[16'h1820] = 16'h027b;
    mdl[16'h1824] = 16'h0000;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    rc(16'h180c);
    rc(16'h1820);
    rc(16'h1824);
    chk("serial_en", 32'h1, {31'h0, serial_en});
    rd(16'h1828);
    chk("an_complete", 32'h0, {31'h0, d[10]});
    rd(16'h1000);
    chk("unmapped_resp", 32'h2, {30'h0, r});
    wr(16'h1000, 16'h1234);
    chk("unmapped_bresp", 32'h2, {30'h0, b});
    // all-zero wake coding is never programmed by software
    for (int w = 1; w < 4; w++) begin
      wr(16'h180c, 16'(w));
      chk("bresp", 32'h0, {30'h0, b});
      rc(16'h180c);
      lpi_exit <= 1'b1;
      repeat (2) @(posedge mclk);
      chk("exit_ctrl", 32'(w >> 1), {31'h0, par_rx_ctrl});
      chk("exit_rxd", (w & 1) ? 32'h0 : 32'h1, {28'h0, par_rxd});
      lpi_exit   <= 1'b0;
      lpi_active <= 1'b1;
      repeat (2) @(posedge mclk);
      chk("idle_ctrl", 32'h0, {31'h0, par_rx_ctrl});
      chk("idle_rxd", 32'h1, {28'h0, par_rxd});
      lpi_active <= 1'b0;
    end
    wr(16'h1824, 16'($urandom));
    rc(16'h1824);
    chk("timers", 32'(mdl[16'h1824]),
        {16'h0, tx_refresh_timer, tx_quiet_timer, tx_sleep_timer, non_eee_mode});
    wr(16'h1820, 16'h007b);
    rc(16'h1820);
    chk("serial_en", 32'h0, {31'h0, serial_en});
    go <= 1'b1;
    repeat (150) @(posedge mclk);
    chk("fifo_fill", 32'd33, 32'(sent));
    chk("tx_ready_full", 32'h0, {31'h0, mac_tx_ready});
    wr(16'h1820, 16'h027b);
    repeat (800) @(posedge mclk);
    chk("fifo_drain", 32'd40, 32'(sent));
    chk("tx_ready_empty", 32'h1, {31'h0, mac_tx_ready});
    chk("tx_words_left", 32'h0, 32'(txq.size()));
    // constant receive word so the forced boundary gives a known rotation
    rx_fix = 10'($urandom);
    pw = rv(~rx_fix);
    rx_hold <= 1'b1;
    wr(16'h1820, 16'h4f7d);
    rc(16'h1820);
    repeat (60) @(posedge mclk);
    chk("mac_rx_word", {22'h0, 10'({pw, pw} >> 3)}, {22'h0, mac_rx_word});
    chk("rx_sync", 32'h1, {31'h0, rx_sync});
    rd(16'h1828);
    chk("status", 32'h0730, d);
    chk("an_timer_done", 32'h1, {31'h0, an_complete});
    wr(16'h1820, 16'h4f7c);
    repeat (2) @(posedge mclk);
    chk("an_off", 32'h0, {31'h0, an_complete});
    wr(16'h1824, 16'h0001);
    lpi_active <= 1'b1;
    repeat (30) @(posedge mclk);
    chk("lpi_hidden", 32'h283, {22'h0, mac_rx_word});
    lpi_active <= 1'b0;
    results();
  end
endmodule : mac_serial_if_config_test

/* design/ser_cfg.sv */
// MAC-side interface configuration: registers, wake signalling, serial word path
`timescale 1ns/10ps
`include "ser_cfg_regs.svh"
module ser_cfg #(
  parameter int         ADDR_W       = 16,
  parameter int         WORD_DIV     = 8,
  parameter int         FIFO_DEPTH   = 32,
  parameter logic [3:0] INBAND_CODE  = 4'h1,
  parameter logic [9:0] IDLE_WORD    = 10'h283,
  parameter logic [9:0] ERR_WORD     = 10'h2e8,
  parameter int         AN_CYC_1P6MS = (`AN_T_1P6MS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int         AN_CYC_800US = (`AN_T_800US_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int         AN_CYC_11MS  = (`AN_T_11MS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic      [1:0]        bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic      [31:0]       rdata,
  output logic      [1:0]        rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // straps
  input  wire logic              strap_bit_zero,
  input  wire logic              strap_bit_one,
  input  wire logic              strap_bit_two,
  // parallel receive toward the MAC
  input  wire logic              lpi_active,
  input  wire logic              lpi_exit,
  input  wire logic [3:0]        core_rxd,
  input  wire logic              core_rx_ctrl,
  output logic      [3:0]        par_rxd,
  output logic                   par_rx_ctrl,
  // serial receive
  input  wire logic [9:0]        serdes_rx_word,
  output logic      [9:0]        mac_rx_word,
  // serial transmit
  input  wire logic [9:0]        mac_tx_word,
  input  wire logic              mac_tx_err,
  input  wire logic              mac_tx_sop,
  input  wire logic              mac_tx_valid,
  output logic                   mac_tx_ready,
  output logic      [9:0]        serdes_tx_word,
  // configuration and status
  output logic                   serial_en,
  output logic                   non_eee_mode,
  output logic      [4:0]        tx_refresh_timer,
  output logic      [4:0]        tx_quiet_timer,
  output logic      [4:0]        tx_sleep_timer,
  output logic                   an_complete,
  output logic                   rx_sync
);
  localparam int AN_CYC_2US           = (`AN_T_2US_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int DIV_W                = $clog2(WORD_DIV + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(WORD_DIV - 1);

  logic [1:0]  wake;
  logic [15:0] ser1;
  logic [15:0] tmr;
  logic        strap_pending;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_fire;
  ser_cfg_pkg::reg_sel_e wr_sel;
  logic [DIV_W-1:0] div_cnt;
  logic        word_tick;
  logic [24:0] hist;
  logic [3:0]  align_idx;
  logic        aligned;
  logic [4:0]  comma;
  logic [31:0] an_cnt;
  logic        tx_even;
  ser_cfg_pkg::tx_state_e tx_state;
  logic        fifo_vld;
  logic [11:0] fifo_word;
  logic        tx_pop;
  logic        tx_send;
  logic [9:0]  tx_word;
  logic [15:0] stat;

  function automatic logic [9:0] rev10(input logic [9:0] w);
    logic [9:0] r;
    for (int i = 0; i < 10; i++) begin
      r[i] = w[9-i];
    end
    return r;
  endfunction : rev10

  function automatic logic [9:0] order_in(input logic [9:0] w, input logic [1:0] sel);
    logic [9:0] r;
    r = rev10(w);
    unique case (sel)
      `ORD_PLAIN:   return w;
      `ORD_SWAP:    return {w[4:0], w[9:5]};
      `ORD_HALFREV: return {r[4:0], r[9:5]};
      `ORD_REV:     return r;
    endcase
  endfunction : order_in

  function automatic logic [9:0] ser_out(input logic [9:0] w, input logic lsb, input logic inv);
    return (lsb ? rev10(w) : w) ^ {10{inv}};
  endfunction : ser_out

  // first comma position in the history, with a found flag on top
  function automatic logic [4:0] find_comma(input logic [24:0] h);
    logic [4:0] f;
    f = '0;
    for (int i = 9; i >= 0; i--) begin
      if (h[i +: `COMMA_W] == `COMMA_P || h[i +: `COMMA_W] == `COMMA_N) begin
        f = {1'b1, 4'(i)};
      end
    end
    return f;
  endfunction : find_comma

  function automatic logic [31:0] an_limit(input logic [1:0] sel);
    unique case (sel)
      `AN_SEL_1P6MS: return 32'(AN_CYC_1P6MS);
      `AN_SEL_2US:   return 32'(AN_CYC_2US);
      `AN_SEL_800US: return 32'(AN_CYC_800US);
      `AN_SEL_11MS:  return 32'(AN_CYC_11MS);
    endcase
  endfunction : an_limit

  function automatic ser_cfg_pkg::reg_sel_e decode(input logic [ADDR_W-1:0] a);
    if (a[`A_LOW] != 2'h0 || (a >> `A_TOP) != '0) begin
      return ser_cfg_pkg::SEL_NONE;
    end
    unique case (a[`A_IDX])
      `IDX_WAKE: return ser_cfg_pkg::SEL_WAKE;
      `IDX_SER1: return ser_cfg_pkg::SEL_SER1;
      `IDX_TMR:  return ser_cfg_pkg::SEL_TMR;
      `IDX_STAT: return ser_cfg_pkg::SEL_STAT;
      default:   return ser_cfg_pkg::SEL_NONE;
    endcase
  endfunction : decode

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction : merge

  // axi write: address and data are taken in either order, response follows both
  assign wr_sel  = decode(wr_addr);
  assign wr_fire = !awready && !wready && !bvalid;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        wready  <= 1'b0;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_fire) begin
        bvalid <= 1'b1;
        bresp  <= (wr_sel == ser_cfg_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // the status word is read-only; writes to it are accepted and dropped
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wake          <= `RST_WAKE;
      ser1          <= `RST_SER1;
      tmr           <= `RST_TMR;
      strap_pending <= 1'b1;
    end else begin
      if (wr_fire && wr_sel == ser_cfg_pkg::SEL_WAKE) begin
        wake <= 2'(merge({14'h0, wake}, wr_data, wr_strb));
      end
      if (wr_fire && wr_sel == ser_cfg_pkg::SEL_SER1) begin
        ser1 <= merge(ser1, wr_data, wr_strb);
      end
      if (wr_fire && wr_sel == ser_cfg_pkg::SEL_TMR) begin
        tmr <= merge(tmr, wr_data, wr_strb);
      end
      // straps are caught on the first edge after release, never under reset
      if (strap_pending) begin
        strap_pending      <= 1'b0;
        ser1[`B_SER_EN]    <= {strap_bit_two, strap_bit_one, strap_bit_zero} == `STRAP_SER;
      end
    end
  end

  always_comb begin
    stat              = '0;
    stat[`S_AN_DONE]  = an_complete;
    stat[`S_ALIGN]    = aligned;
    stat[`S_SYNC]     = rx_sync;
    stat[`F_S_IDX]    = align_idx;
  end

  // axi read: answered on the same edge that takes the address
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rresp   <= `RESP_OKAY;
      unique case (decode(araddr))
        ser_cfg_pkg::SEL_WAKE: rdata <= {30'h0, wake};
        ser_cfg_pkg::SEL_SER1: rdata <= {16'h0, ser1};
        ser_cfg_pkg::SEL_TMR:  rdata <= {16'h0, tmr};
        ser_cfg_pkg::SEL_STAT: rdata <= {16'h0, stat};
        ser_cfg_pkg::SEL_NONE: begin
          rdata <= '0;
          rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
  end

  always_comb begin
    serial_en        = ser1[`B_SER_EN];
    non_eee_mode     = tmr[`B_NONEEE];
    tx_refresh_timer = tmr[`F_TR];
    tx_quiet_timer   = tmr[`F_TQ];
    tx_sleep_timer   = tmr[`F_TS];
  end

  // parallel receive during low-power idle and its exit
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      par_rx_ctrl <= 1'b0;
      par_rxd     <= '0;
    end else if (lpi_exit) begin
      par_rx_ctrl <= wake[`W_CTRL];
      par_rxd     <= wake[`W_DATA] ? 4'h0 : INBAND_CODE;
    end else if (lpi_active) begin
      par_rx_ctrl <= 1'b0;
      par_rxd     <= INBAND_CODE;
    end else begin
      par_rx_ctrl <= core_rx_ctrl;
      par_rxd     <= core_rxd;
    end
  end

  // word-rate enable for the serial path
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_cnt   <= '0;
      word_tick <= 1'b0;
    end else begin
      word_tick <= div_cnt == DIV_LAST;
      div_cnt   <= (div_cnt == DIV_LAST) ? '0 : div_cnt + DIV_W'(1);
    end
  end

  // receive: polarity first, then bit order, then word boundary
  assign comma = find_comma(hist);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hist      <= '0;
      align_idx <= '0;
      aligned   <= 1'b0;
      rx_sync   <= 1'b0;
    end else if (word_tick) begin
      hist <= {hist[14:0],
               order_in(serdes_rx_word ^ {10{ser1[`B_RXPOL]}}, ser1[`F_TXORD])};
      if (ser1[`B_FORCE]) begin
        align_idx <= ser1[`F_IDX];
        aligned   <= 1'b1;
        rx_sync   <= 1'b1;
      end else if (comma[4]) begin
        align_idx <= comma[3:0];
        aligned   <= 1'b1;
        rx_sync   <= 1'b1;
      end else begin
        aligned <= 1'b0;
      end
    end
  end

  // a MAC without low-power support sees idle words while low-power idle is active
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mac_rx_word <= '0;
    end else if (word_tick) begin
      if (!serial_en) begin
        mac_rx_word <= '0;
      end else if (non_eee_mode && lpi_active) begin
        mac_rx_word <= IDLE_WORD;
      end else begin
        mac_rx_word <= hist[align_idx +: 10];
      end
    end
  end

  // autonegotiation timer runs on the core clock once the link is in sync
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      an_cnt      <= '0;
      an_complete <= 1'b0;
    end else if (!ser1[`B_AN_EN] || !serial_en || !rx_sync) begin
      an_cnt      <= '0;
      an_complete <= 1'b0;
    end else if (!an_complete) begin
      if (an_cnt == an_limit(ser1[`F_ANT]) - 32'h1) begin
        an_complete <= 1'b1;
      end else begin
        an_cnt <= an_cnt + 32'h1;
      end
    end
  end

  ser_cfg_fifo #(
    .WIDTH (12),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (mac_tx_valid),
    .in_ready  (mac_tx_ready),
    .in_data   ({mac_tx_sop, mac_tx_err, mac_tx_word}),
    .out_valid (fifo_vld),
    .out_ready (tx_pop),
    .out_data  (fifo_word)
  );

  // a packet start waits for the even slot; words outside a packet are dropped
  assign tx_pop  = word_tick && serial_en && fifo_vld &&
                   (!fifo_word[11] || !ser1[`B_ALIGN] || tx_even);
  assign tx_send = tx_pop && (tx_state == ser_cfg_pkg::TX_PKT || fifo_word[11]);
  assign tx_word = (fifo_word[10] && !ser1[`B_TXERR_DIS]) ? ERR_WORD : fifo_word[9:0];

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_state <= ser_cfg_pkg::TX_IDLE;
      tx_even  <= 1'b0;
    end else if (word_tick) begin
      tx_even <= !tx_even;
      unique case (tx_state)
        ser_cfg_pkg::TX_IDLE: begin
          if (tx_pop && fifo_word[11]) begin
            tx_state <= ser_cfg_pkg::TX_PKT;
          end
        end
        ser_cfg_pkg::TX_PKT: begin
          if (!fifo_vld || !serial_en) begin
            tx_state <= ser_cfg_pkg::TX_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      serdes_tx_word <= '0;
    end else if (word_tick) begin
      serdes_tx_word <= !serial_en ? 10'h0 :
                        ser_out(tx_send ? tx_word : IDLE_WORD,
                                ser1[`B_RXORD], ser1[`B_TXPOL]);
    end
  end

  a_wake_ctrl: assert property (@(posedge mclk) disable iff (rst)
    lpi_exit |=> par_rx_ctrl == $past(wake[`W_CTRL]))
    else $error("rx control wrong during idle exit");
  a_wake_data: assert property (@(posedge mclk) disable iff (rst)
    lpi_exit && !wake[`W_DATA] |=> par_rxd == INBAND_CODE)
    else $error("rx data not in-band code during idle exit");
  a_strap_load: assert property (@(posedge mclk) disable iff (rst)
    $fell(strap_pending) |-> serial_en ==
      ($past({strap_bit_two, strap_bit_one, strap_bit_zero}) == `STRAP_SER))
    else $error("serial enable not taken from straps");
  a_force_idx: assert property (@(posedge mclk) disable iff (rst)
    word_tick && ser1[`B_FORCE] |=> align_idx == $past(ser1[`F_IDX]) && aligned)
    else $error("forced boundary index not applied");
  a_an_off: assert property (@(posedge mclk) disable iff (rst)
    !ser1[`B_AN_EN] |=> !an_complete && an_cnt == 32'h0)
    else $error("autoneg ran while disabled");
  a_an_timer: assert property (@(posedge mclk) disable iff (rst)
    $rose(an_complete) |-> $past(an_cnt) == an_limit($past(ser1[`F_ANT])) - 32'h1)
    else $error("autoneg timer length wrong");
  a_an_status: assert property (@(posedge mclk) disable iff (rst)
    arvalid && arready && decode(araddr) == ser_cfg_pkg::SEL_STAT
      |=> rvalid && rdata[`S_AN_DONE] == $past(an_complete))
    else $error("status does not show autoneg completion");
  a_pkt_align: assert property (@(posedge mclk) disable iff (rst)
    tx_pop && fifo_word[11] && ser1[`B_ALIGN] |-> tx_even)
    else $error("packet started off the even slot");
  a_tx_idle: assert property (@(posedge mclk) disable iff (rst)
    word_tick && serial_en && !tx_send
      |=> serdes_tx_word == ser_out(IDLE_WORD, $past(ser1[`B_RXORD]), $past(ser1[`B_TXPOL])))
    else $error("idle word order or polarity wrong");
  a_rx_nolpi: assert property (@(posedge mclk) disable iff (rst)
    word_tick && serial_en && non_eee_mode && lpi_active |=> mac_rx_word == IDLE_WORD)
    else $error("low-power idle leaked to MAC");
endmodule : ser_cfg

/* design/ser_cfg_fifo.sv */
// word fifo with valid/ready on both sides; output stage holds one extra word
`timescale 1ns/10ps
module ser_cfg_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32,
  localparam int AW   = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   cnt;
  logic [AW:0]   next_cnt;
  logic          push;
  logic          pull;

  assign push = in_valid && in_ready;
  // refill the output stage whenever it is empty or being taken
  assign pull = (cnt != '0) && (!out_valid || out_ready);

  always_comb begin
    next_cnt = cnt;
    if (push && !pull) begin
      next_cnt = cnt + (AW+1)'(1);
    end else if (pull && !push) begin
      next_cnt = cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt      <= '0;
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      in_ready <= 1'b1;
    end else begin
      cnt      <= next_cnt;
      in_ready <= next_cnt != FULL_CNT;
      if (push) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (pull) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
    end else if (pull) begin
      out_valid <= 1'b1;
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

  ser_cfg_mem #(
    .WIDTH (WIDTH),
    .DEPTH (DEPTH)
  ) u_mem (
    .mclk  (mclk),
    .rst   (rst),
    .we    (push),
    .waddr (wr_ptr),
    .wdata (in_data),
    .re    (pull),
    .raddr (rd_ptr),
    .rdata (out_data)
  );
endmodule : ser_cfg_fifo

/* design/ser_cfg_mem.sv */
// small word memory with registered read data
`timescale 1ns/10ps
module ser_cfg_mem #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 32,
  localparam int AW   = $clog2(DEPTH)
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // write side
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // read side
  input  wire logic             re,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] store [DEPTH];

  always_ff @(posedge mclk) begin
    if (we) begin
      store[waddr] <= wdata;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (re) begin
      rdata <= store[raddr];
    end
  end
endmodule : ser_cfg_mem

/* design/ser_cfg_pkg.sv */
// types shared by the serial interface configuration block
package ser_cfg_pkg;
  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_WAKE = 3'b001,
    SEL_SER1 = 3'b010,
    SEL_TMR  = 3'b011,
    SEL_STAT = 3'b100
  } reg_sel_e;
  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_PKT  = 1'b1
  } tx_state_e;
endpackage : ser_cfg_pkg

/* design/ser_cfg_regs.svh */
// register map, field positions, reset values and timing constants
`ifndef SER_CFG_REGS_SVH
`define SER_CFG_REGS_SVH
`define IDX_WAKE      12'h603
`define IDX_SER1      12'h608
`define IDX_TMR       12'h609
`define IDX_STAT      12'h60a
`define A_IDX         13:2
`define A_LOW         1:0
`define A_TOP         14
`define RST_WAKE      2'h3
`define RST_SER1      16'h007b
`define RST_TMR       16'h0000
`define W_CTRL        1
`define W_DATA        0
`define B_TXERR_DIS   15
`define B_FORCE       14
`define F_IDX         13:10
`define B_SER_EN      9
`define B_RXPOL       8
`define B_TXPOL       7
`define F_TXORD       6:5
`define B_RXORD       4
`define B_ALIGN       3
`define F_ANT         2:1
`define B_AN_EN       0
`define F_TR          15:11
`define F_TQ          10:6
`define F_TS          5:1
`define B_NONEEE      0
`define S_AN_DONE     10
`define S_ALIGN       9
`define S_SYNC        8
`define F_S_IDX       7:4
`define STRAP_SER     3'h0
`define ORD_PLAIN     2'h0
`define ORD_SWAP      2'h1
`define ORD_HALFREV   2'h2
`define ORD_REV       2'h3
`define AN_SEL_1P6MS  2'h0
`define AN_SEL_2US    2'h1
`define AN_SEL_800US  2'h2
`define AN_SEL_11MS   2'h3
`define CLK_PERIOD_NS 5
`define AN_T_1P6MS_NS 1600000
`define AN_T_2US_NS   2000
`define AN_T_800US_NS 800000
`define AN_T_11MS_NS  11000000
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`define COMMA_P       7'h1f
`define COMMA_N       7'h60
`define COMMA_W       7
`endif
